// ---- hdl/cpd_counter_param.sv ----
`timescale 1ns/100ps
// Contract
// [RL1] Track A code 00h gives 500kHz limit, 01h gives 300kHz.
// [RL2] Track B has its own code byte: 300kHz, 100kHz, 10kHz selectable.
// [RL3] Tracks filtered per limit; reset input filter fixed at 100kHz, 02h.
// [RL4] Interrupt byte bit 2 enables overflow process interrupt.
// [RL5] Interrupt byte bit 3 enables underflow process interrupt.
// [RL6] Interrupt byte bit 4 enables comparison process interrupt.
// [RL7] Interrupt byte bit 5 enables end value process interrupt.
// [RL8] Interrupt source passes only while its enable bit is set.
// [RL9] Function selector in bits 5..0; bits 7..6 held zero.
// [RL10] Function value zero selects endless counting.
// [RL11] Codes 01h, 02h, 04h select once forward, backwards, no direction.
// [RL12] Codes 08h, 10h, 20h select periodic forward, backwards, none.
// [RL13] Host writes interrupt and function bytes only while stopped.
// [RL14] Interrupt byte bits 0, 1, 6, 7 read zero, writes ignored.
// [RL15] Unlisted function code flags error, keeps active counting mode.
module cpd_counter_param
	import cpd_pkg::*;
#(
	parameter int CYC_10K = CPD_CYC_10K
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       prm_wr,
	input  wire logic       prm_rd,
	input  wire logic [3:0] prm_idx,
	input  wire logic [7:0] prm_wdata,
	output logic      [7:0] prm_rdata,
	input  wire logic       sys_stopped,
	input  wire logic       track_a_pin,
	input  wire logic       track_b_pin,
	input  wire logic       reset_pin,
	output logic            track_a_filt,
	output logic            track_b_filt,
	output logic            reset_filt,
	input  wire logic       ev_ovf,
	input  wire logic       ev_unf,
	input  wire logic       ev_cmp,
	input  wire logic       ev_end,
	output logic            irq_ovf,
	output logic            irq_unf,
	output logic            irq_cmp,
	output logic            irq_end,
	output logic      [1:0] cnt_mode,
	output logic      [1:0] cnt_dir,
	output logic            param_err
);
	typedef logic [CPD_CNT_W-1:0] cpd_cnt_t;

	typedef struct packed {
		logic [2:0][1:0] sync;
		logic [2:0]      filt;
		cpd_cnt_t [2:0]  cnt;
		logic [7:0]      flt_a;
		logic [7:0]      flt_b;
		logic [7:0]      int_en;
		logic [7:0]      fct;
		logic [1:0]      mode;
		logic [1:0]      dir;
		logic            perr;
		logic [7:0]      rdata;
		logic [3:0]      irq;
	} cpd_state_t;

	cpd_state_t s_reg;
	cpd_state_t s_next;
	logic       rst_q1_reg;
	logic       rst_sync_b;
	cpd_cnt_t   lim [3];
	logic [2:0] pins;
	logic       fct_ok;
	logic [1:0] fct_mode;
	logic [1:0] fct_dir;

	// Filter code to stable-cycle limit
	function automatic cpd_cnt_t cpd_limit(input logic [7:0] code);
		case (code)
			CPD_FLT_500K: cpd_limit = CPD_CNT_W'(CPD_CYC_500K);
			CPD_FLT_300K: cpd_limit = CPD_CNT_W'(CPD_CYC_300K);
			CPD_FLT_10K:  cpd_limit = CPD_CNT_W'(CYC_10K);
			default:      cpd_limit = CPD_CNT_W'(CPD_CYC_100K);
		endcase
	endfunction

	// Reset release synchroniser
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_q1_reg <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_q1_reg <= 1'b1;
			rst_sync_b <= rst_q1_reg;
		end
	end

	// [RL1] [RL2] Limit selection
	assign lim[0] = cpd_limit(s_reg.flt_a);
	assign lim[1] = cpd_limit(s_reg.flt_b);
	// [RL3] Reset input fixed limit
	assign lim[2] = CPD_CNT_W'(CPD_CYC_100K);
	assign pins   = {reset_pin, track_b_pin, track_a_pin};

	// [RL10] [RL11] [RL12] One-hot function decode
	always_comb begin
		fct_ok   = 1'b1;
		fct_mode = CPD_MODE_ENDLESS;
		fct_dir  = CPD_DIR_NONE;
		case (prm_wdata)
			CPD_FCT_ENDLESS: ;
			CPD_FCT_ONCE_FWD: begin
				fct_mode = CPD_MODE_ONCE;
				fct_dir  = CPD_DIR_FWD;
			end
			CPD_FCT_ONCE_BWD: begin
				fct_mode = CPD_MODE_ONCE;
				fct_dir  = CPD_DIR_BWD;
			end
			CPD_FCT_ONCE_NON: fct_mode = CPD_MODE_ONCE;
			CPD_FCT_PER_FWD: begin
				fct_mode = CPD_MODE_PERIODIC;
				fct_dir  = CPD_DIR_FWD;
			end
			CPD_FCT_PER_BWD: begin
				fct_mode = CPD_MODE_PERIODIC;
				fct_dir  = CPD_DIR_BWD;
			end
			CPD_FCT_PER_NON: fct_mode = CPD_MODE_PERIODIC;
			default: fct_ok = 1'b0;
		endcase
	end

	// Next-state logic
	always_comb begin
		s_next = s_reg;
		// [RL3] Sync and glitch filter
		for (int i = 0; i < 3; i++) begin
			s_next.sync[i] = {s_reg.sync[i][0], pins[i]};
			if (s_reg.sync[i][1] == s_reg.filt[i]) begin
				s_next.cnt[i] = '0;
			end else if (s_reg.cnt[i] + 1'b1 >= lim[i]) begin
				s_next.filt[i] = s_reg.sync[i][1];
				s_next.cnt[i]  = '0;
			end else begin
				s_next.cnt[i] = s_reg.cnt[i] + 1'b1;
			end
		end
		// Parameter writes
		if (prm_wr) begin
			case (prm_idx)
				CPD_IDX_TRACK_A: s_next.flt_a = prm_wdata;
				CPD_IDX_TRACK_B: s_next.flt_b = prm_wdata;
				// [RL13] [RL14] Masked enable write
				CPD_IDX_INT_EN: begin
					if (sys_stopped)
						s_next.int_en = prm_wdata & CPD_INT_MASK;
				end
				// [RL9] [RL13] [RL15] Function write
				CPD_IDX_FCT: begin
					if (sys_stopped && fct_ok) begin
						s_next.fct  = prm_wdata;
						s_next.mode = fct_mode;
						s_next.dir  = fct_dir;
						s_next.perr = 1'b0;
					end else if (sys_stopped) begin
						s_next.perr = 1'b1;
					end
				end
				default: ;
			endcase
		end
		// Read data, reserved and unmapped read zero
		if (prm_rd) begin
			case (prm_idx)
				CPD_IDX_TRACK_A: s_next.rdata = s_reg.flt_a;
				CPD_IDX_TRACK_B: s_next.rdata = s_reg.flt_b;
				CPD_IDX_RESET:   s_next.rdata = CPD_FLT_100K;
				CPD_IDX_INT_EN:  s_next.rdata = s_reg.int_en;
				CPD_IDX_FCT:     s_next.rdata = s_reg.fct;
				default:         s_next.rdata = 8'h00;
			endcase
		end
		// [RL4] [RL5] [RL6] [RL7] [RL8] Enable gating
		s_next.irq = {ev_end & s_reg.int_en[CPD_INT_END_BIT],
			ev_cmp & s_reg.int_en[CPD_INT_CMP_BIT],
			ev_unf & s_reg.int_en[CPD_INT_UNF_BIT],
			ev_ovf & s_reg.int_en[CPD_INT_OVF_BIT]};
	end

	// State register
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			s_reg        <= '0;
			s_reg.flt_a  <= CPD_FLT_RST;
			s_reg.flt_b  <= CPD_FLT_RST;
			s_reg.int_en <= CPD_INT_RST;
			s_reg.fct    <= CPD_FCT_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Outputs straight from flops
	assign prm_rdata    = s_reg.rdata;
	assign track_a_filt = s_reg.filt[0];
	assign track_b_filt = s_reg.filt[1];
	assign reset_filt   = s_reg.filt[2];
	assign irq_ovf      = s_reg.irq[0];
	assign irq_unf      = s_reg.irq[1];
	assign irq_cmp      = s_reg.irq[2];
	assign irq_end      = s_reg.irq[3];
	assign cnt_mode     = s_reg.mode;
	assign cnt_dir      = s_reg.dir;
	assign param_err    = s_reg.perr;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_sync_b);

	chk_a_limit_code: assert property ( // [RL1]
		s_reg.flt_a == CPD_FLT_500K |-> lim[0] == CPD_CNT_W'(100))
		else $error("track A limit wrong for code 00h");
	chk_b_limit_code: assert property ( // [RL2]
		s_reg.flt_b == CPD_FLT_10K |-> lim[1] == CPD_CNT_W'(CYC_10K))
		else $error("track B limit wrong for 10kHz code");
	chk_a_filter_hold: assert property ( // [RL3]
		$changed(track_a_filt) |-> $past(s_reg.cnt[0]) == $past(lim[0]) - 1'b1)
		else $error("track A filter changed before limit");
	chk_reset_filter_fix: assert property ( // [RL3]
		$changed(reset_filt) |-> $past(s_reg.cnt[2]) ==
			CPD_CNT_W'(CPD_CYC_100K - 1))
		else $error("reset filter not at 100kHz limit");
	chk_ovf_gate: assert property ( // [RL4]
		irq_ovf |-> $past(ev_ovf) && $past(s_reg.int_en[2]))
		else $error("overflow interrupt without enable");
	chk_unf_gate: assert property ( // [RL5]
		ev_unf && s_reg.int_en[3] |=> irq_unf)
		else $error("underflow interrupt lost");
	chk_cmp_gate: assert property ( // [RL6]
		ev_cmp && !s_reg.int_en[4] |=> !irq_cmp)
		else $error("comparison interrupt not suppressed");
	chk_end_gate: assert property ( // [RL7] [RL8]
		irq_end |-> $past(ev_end) && $past(s_reg.int_en[5]))
		else $error("end value interrupt without enable");
	chk_fct_rsvd_zero: assert property ( // [RL9] [RL14]
		s_reg.fct[7:6] == 2'h0 && (s_reg.int_en & ~CPD_INT_MASK) == 8'h00)
		else $error("fixed-zero bits set");
	chk_endless_decode: assert property ( // [RL10]
		prm_wr && sys_stopped && prm_idx == CPD_IDX_FCT && prm_wdata == 8'h00
		|=> cnt_mode == CPD_MODE_ENDLESS && cnt_dir == CPD_DIR_NONE)
		else $error("endless mode not decoded");
	chk_once_bwd: assert property ( // [RL11]
		prm_wr && sys_stopped && prm_idx == CPD_IDX_FCT && prm_wdata == 8'h02
		|=> cnt_mode == CPD_MODE_ONCE && cnt_dir == CPD_DIR_BWD)
		else $error("once backwards not decoded");
	chk_per_fwd: assert property ( // [RL12]
		prm_wr && sys_stopped && prm_idx == CPD_IDX_FCT && prm_wdata == 8'h08
		|=> cnt_mode == CPD_MODE_PERIODIC && cnt_dir == CPD_DIR_FWD)
		else $error("periodic forward not decoded");
	chk_bad_fct_keep: assert property ( // [RL15]
		prm_wr && sys_stopped && prm_idx == CPD_IDX_FCT && !fct_ok
		|=> param_err && $stable(cnt_mode) && $stable(cnt_dir))
		else $error("bad function code changed mode");
	chk_run_write_block: assert property ( // [RL13]
		prm_wr && !sys_stopped && prm_idx == CPD_IDX_INT_EN
		|=> $stable(s_reg.int_en))
		else $error("enable byte changed while running");
	chk_run_fct_block: assert property ( // [RL13]
		prm_wr && !sys_stopped && prm_idx == CPD_IDX_FCT
		|=> $stable(cnt_mode) && $stable(cnt_dir) && $stable(param_err))
		else $error("function byte changed while running");

	cov_filter_a: cover property ($rose(track_a_filt));
	cov_irq_ovf: cover property (irq_ovf);
	cov_periodic: cover property (cnt_mode == CPD_MODE_PERIODIC);
	cov_param_err: cover property ($rose(param_err));
endmodule // cpd_counter_param

// ---- shared/cpd_pkg.sv ----
package cpd_pkg;
	// Parameter record byte indices
	localparam logic [3:0] CPD_IDX_TRACK_A = 4'h1;
	localparam logic [3:0] CPD_IDX_TRACK_B = 4'h2;
	localparam logic [3:0] CPD_IDX_RESET   = 4'h3;
	localparam logic [3:0] CPD_IDX_RSVD    = 4'h4;
	localparam logic [3:0] CPD_IDX_INT_EN  = 4'h5;
	localparam logic [3:0] CPD_IDX_FCT     = 4'h6;

	// Reset values
	localparam logic [7:0] CPD_FLT_RST    = 8'h02;
	localparam logic [7:0] CPD_INT_RST    = 8'h00;
	localparam logic [7:0] CPD_FCT_RST    = 8'h00;

	// Filter codes
	localparam logic [7:0] CPD_FLT_500K   = 8'h00;
	localparam logic [7:0] CPD_FLT_300K   = 8'h01;
	localparam logic [7:0] CPD_FLT_100K   = 8'h02;
	localparam logic [7:0] CPD_FLT_10K    = 8'h03;

	// Interrupt enable bit positions and writable mask
	localparam int         CPD_INT_OVF_BIT = 2;
	localparam int         CPD_INT_UNF_BIT = 3;
	localparam int         CPD_INT_CMP_BIT = 4;
	localparam int         CPD_INT_END_BIT = 5;
	localparam logic [7:0] CPD_INT_MASK    = 8'h3c;

	// Counter function codes
	localparam logic [7:0] CPD_FCT_ENDLESS  = 8'h00;
	localparam logic [7:0] CPD_FCT_ONCE_FWD = 8'h01;
	localparam logic [7:0] CPD_FCT_ONCE_BWD = 8'h02;
	localparam logic [7:0] CPD_FCT_ONCE_NON = 8'h04;
	localparam logic [7:0] CPD_FCT_PER_FWD  = 8'h08;
	localparam logic [7:0] CPD_FCT_PER_BWD  = 8'h10;
	localparam logic [7:0] CPD_FCT_PER_NON  = 8'h20;

	// Decoded mode and direction
	localparam logic [1:0] CPD_MODE_ENDLESS  = 2'h0;
	localparam logic [1:0] CPD_MODE_ONCE     = 2'h1;
	localparam logic [1:0] CPD_MODE_PERIODIC = 2'h2;
	localparam logic [1:0] CPD_DIR_NONE      = 2'h0;
	localparam logic [1:0] CPD_DIR_FWD       = 2'h1;
	localparam logic [1:0] CPD_DIR_BWD       = 2'h2;

	// Filter timing: least stable pulse width is half a period
	localparam int CPD_CLK_PERIOD_NS = 10;
	localparam int CPD_T500K_NS      = 1000;
	localparam int CPD_T300K_NS      = 1667;
	localparam int CPD_T100K_NS      = 5000;
	localparam int CPD_T10K_NS       = 50000;
	localparam int CPD_CYC_500K =
		(CPD_T500K_NS + CPD_CLK_PERIOD_NS - 1) / CPD_CLK_PERIOD_NS;
	localparam int CPD_CYC_300K =
		(CPD_T300K_NS + CPD_CLK_PERIOD_NS - 1) / CPD_CLK_PERIOD_NS;
	localparam int CPD_CYC_100K =
		(CPD_T100K_NS + CPD_CLK_PERIOD_NS - 1) / CPD_CLK_PERIOD_NS;
	localparam int CPD_CYC_10K =
		(CPD_T10K_NS + CPD_CLK_PERIOD_NS - 1) / CPD_CLK_PERIOD_NS;
	localparam int CPD_CNT_W = 13;
endpackage

// ---- tb/cpd_host_model.sv ----
`timescale 1ns/100ps
// Host side of the parameter port, driving on the falling edge
module cpd_host_model (
	input  wire logic       clk_sys,
	output logic            prm_wr,
	output logic            prm_rd,
	output logic      [3:0] prm_idx,
	output logic      [7:0] prm_wdata,
	input  wire logic [7:0] prm_rdata
);
	// Idle bus at time zero
	initial begin
		prm_wr = 1'b0;
		prm_rd = 1'b0;
		prm_idx = 4'h0;
		prm_wdata = 8'h00;
	end

	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		@(negedge clk_sys);
		prm_wr = 1'b1;
		prm_idx = idx;
		prm_wdata = d;
		@(negedge clk_sys);
		prm_wr = 1'b0;
		prm_wdata = ~d; // Stale data never looks valid
	endtask

	// Read strobe, then sample the held answer a cycle later
	task automatic rd(input logic [3:0] idx, output logic [7:0] d);
		@(negedge clk_sys);
		prm_rd = 1'b1;
		prm_idx = idx;
		@(negedge clk_sys);
		prm_rd = 1'b0;
		@(negedge clk_sys);
		d = prm_rdata;
	endtask
endmodule // cpd_host_model

// ---- tb/test_counter_parameter_decode.sv ----
`timescale 1ns/100ps
module test_counter_parameter_decode;
	import cpd_pkg::*;
	logic       clk_sys = 1'b0;
	logic       rst_b = 1'b0;
	logic       sys_stopped = 1'b1;
	logic [2:0] pin = 3'h0;
	logic [3:0] ev = 4'h0;
	wire  [2:0] filt;
	wire  [3:0] irq;
	wire  [1:0] cnt_mode;
	wire  [1:0] cnt_dir;
	wire        param_err;
	wire        prm_wr;
	wire        prm_rd;
	wire  [3:0] prm_idx;
	wire  [7:0] prm_wdata;
	wire  [7:0] prm_rdata;
	int         err_total = 0;
	int         n_compared = 0;
	logic [7:0] rv [7] = '{8'h00, 8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00};
	logic [7:0] fc [7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20};
	logic [1:0] fm [7] = '{2'h0, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2};
	logic [1:0] fd [7] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2, 2'h0};

	always #5 clk_sys = ~clk_sys;

	cpd_host_model host (.clk_sys(clk_sys), .prm_wr(prm_wr), .prm_rd(prm_rd),
		.prm_idx(prm_idx), .prm_wdata(prm_wdata), .prm_rdata(prm_rdata));

	cpd_counter_param #(.CYC_10K(20)) dut (.clk_sys(clk_sys), .rst_b(rst_b),
		.prm_wr(prm_wr), .prm_rd(prm_rd), .prm_idx(prm_idx),
		.prm_wdata(prm_wdata), .prm_rdata(prm_rdata),
		.sys_stopped(sys_stopped), .track_a_pin(pin[0]),
		.track_b_pin(pin[1]), .reset_pin(pin[2]), .track_a_filt(filt[0]),
		.track_b_filt(filt[1]), .reset_filt(filt[2]), .ev_ovf(ev[0]),
		.ev_unf(ev[1]), .ev_cmp(ev[2]), .ev_end(ev[3]), .irq_ovf(irq[0]),
		.irq_unf(irq[1]), .irq_cmp(irq[2]), .irq_end(irq[3]),
		.cnt_mode(cnt_mode), .cnt_dir(cnt_dir), .param_err(param_err));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic close_out();
		$display("compares %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask

	task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(idx, d);
		chk(d, exp);
	endtask

	// Short pulse suppressed, long level passes near the limit
	task automatic flt(input int k, input int lim);
		pin[k] = 1'b1;
		cyc(lim / 2);
		pin[k] = 1'b0;
		cyc(lim + 5);
		chk({7'h0, filt[k]}, 8'h00);
		pin[k] = 1'b1;
		cyc(lim - 3);
		chk({7'h0, filt[k]}, 8'h00);
		cyc(8);
		chk({7'h0, filt[k]}, 8'h01);
		pin[k] = 1'b0;
		cyc(lim + 8);
		chk({7'h0, filt[k]}, 8'h00);
	endtask

	// Enable byte, then all four events in one cycle
	task automatic ie(input logic [7:0] en);
		host.wr(4'h5, en);
		rdchk(4'h5, en & 8'h3c);
		ev = 4'hf;
		@(negedge clk_sys);
		chk({4'h0, irq}, {4'h0, en[5:2]});
		ev = 4'h0;
		@(negedge clk_sys);
		chk({4'h0, irq}, 8'h00);
		cyc(1);
		chk({4'h0, irq}, 8'h00);
	endtask

	task automatic fn(input logic [7:0] c, input logic [1:0] m,
		input logic [1:0] d, input logic e);
		host.wr(4'h6, c);
		cyc(2);
		chk({2'h0, cnt_mode, cnt_dir, 1'b0, param_err},
			{2'h0, m, d, 1'b0, e});
	endtask

	// Main sequence
	initial begin
		cyc(12);
		rst_b = 1'b1;
		cyc(4);
		for (int i = 1; i < 7; i++) rdchk(i[3:0], rv[i]);
		rdchk(4'hf, 8'h00);
		host.wr(4'h3, 8'h00);
		host.wr(4'h4, 8'h55);
		rdchk(4'h3, 8'h02);
		rdchk(4'h4, 8'h00);
		flt(2, 500);
		host.wr(4'h1, 8'h00);
		host.wr(4'h2, 8'h03);
		flt(0, 100);
		flt(1, 20);
		host.wr(4'h1, 8'h01);
		rdchk(4'h1, 8'h01);
		flt(0, 167);
		ie(8'hff);
		for (int i = 2; i < 6; i++) ie(8'h01 << i);
		ie(8'h00);
		for (int i = 0; i < 7; i++) begin
			fn(fc[i], fm[i], fd[i], 1'b0);
			rdchk(4'h6, fc[i]);
		end
		fn(8'h03, 2'h2, 2'h0, 1'b1);
		fn(8'h40, 2'h2, 2'h0, 1'b1);
		sys_stopped = 1'b0;
		fn(8'h01, 2'h2, 2'h0, 1'b1);
		host.wr(4'h5, 8'h3c);
		rdchk(4'h5, 8'h00);
		close_out();
	end
endmodule // test_counter_parameter_decode
